// ---- rtl/arcb_regs.sv ----
// ADC repeat, buffer configuration and locked calibration register bank
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
module arcb_regs #(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // Repeat control to the conversion sequencer
   output logic repeat_enable,
   output logic [7:0] repeat_count,
   // Buffer controls to the analog front end
   output logic pd_offset_cancel,
   output logic pd_adc_buf,
   output logic pd_pga,
   output logic pd_front_pos,
   output logic pd_front_neg,
   output logic nochop_offset_cancel,
   output logic nochop_adc_buf,
   output logic nochop_pga,
   output logic nochop_front,
   // Calibration state
   output logic cal_unlocked,
   output logic [arcb_pkg::NUM_CAL*arcb_pkg::CAL_W-1:0] cal_values
);
   localparam int IW = $clog2(arcb_pkg::NUM_CAL);

   // ==========================================
   // Control registers
   logic rep_en_q, rep_en_d;
   logic [7:0] rep_cnt_q, rep_cnt_d;
   logic [4:0] pwrdn_q, pwrdn_d;
   logic [3:0] nochop_q, nochop_d;
   logic [31:0] key_q, key_d;
   logic unlocked_q, unlocked_d;

   // Address decode
   logic hit_rep, hit_buf, hit_key, hit_cal;
   logic [IW-1:0] cal_idx;
   always_comb begin
      hit_rep = (reg_addr == arcb_pkg::REPEAT_CTRL_OFF);
      hit_buf = (reg_addr == arcb_pkg::BUF_CFG_OFF);
      hit_key = (reg_addr == arcb_pkg::UNLOCK_KEY_OFF);
      hit_cal = 1'b0;
      cal_idx = '0;
      for (int i = 0; i < arcb_pkg::NUM_CAL; i++) begin
         if (reg_addr == arcb_pkg::CAL_OFF[i]) begin
            hit_cal = 1'b1;
            cal_idx = i[IW-1:0];
         end
      end
   end

   // ==========================================
   // Next state
   always_comb begin
      rep_en_d = rep_en_q;
      rep_cnt_d = rep_cnt_q;
      pwrdn_d = pwrdn_q;
      nochop_d = nochop_q;
      key_d = key_q;
      if (reg_wr && hit_rep) begin
         rep_en_d = reg_wdata[arcb_pkg::REPEAT_EN_BIT];
         // Zero is stored as written; its meaning is left to the sequencer
         rep_cnt_d = reg_wdata[arcb_pkg::REPEAT_CNT_LSB +: arcb_pkg::REPEAT_CNT_W];
      end
      if (reg_wr && hit_buf) begin
         pwrdn_d = reg_wdata[arcb_pkg::PWRDN_LSB +: arcb_pkg::PWRDN_W];
         nochop_d = reg_wdata[arcb_pkg::NOCHOP_LSB +: arcb_pkg::NOCHOP_W];
      end
      if (reg_wr && hit_key) key_d = reg_wdata;
      unlocked_d = (key_d == arcb_pkg::UNLOCK_KEY_VAL);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rep_en_q <= arcb_pkg::REPEAT_CTRL_RST[arcb_pkg::REPEAT_EN_BIT];
         rep_cnt_q <= arcb_pkg::REPEAT_CTRL_RST[arcb_pkg::REPEAT_CNT_LSB +: arcb_pkg::REPEAT_CNT_W];
         pwrdn_q <= arcb_pkg::BUF_CFG_RST[arcb_pkg::PWRDN_LSB +: arcb_pkg::PWRDN_W];
         nochop_q <= arcb_pkg::BUF_CFG_RST[arcb_pkg::NOCHOP_LSB +: arcb_pkg::NOCHOP_W];
         key_q <= arcb_pkg::UNLOCK_KEY_RST;
         unlocked_q <= 1'b0;
      end else begin
         rep_en_q <= rep_en_d;
         rep_cnt_q <= rep_cnt_d;
         pwrdn_q <= pwrdn_d;
         nochop_q <= nochop_d;
         key_q <= key_d;
         unlocked_q <= unlocked_d;
      end
   end

   // ==========================================
   // Calibration store
   logic cal_wr;
   logic [arcb_pkg::CAL_W-1:0] cal_rdata;
   // Gate on the held key, so a key write and a cal write take effect in order
   assign cal_wr = reg_wr && hit_cal && unlocked_q;
   arcb_cal_mem #(.DEPTH(arcb_pkg::NUM_CAL), .WIDTH(arcb_pkg::CAL_W)) u_cal (
      .mclk(mclk),
      .rst(rst),
      .wr_en(cal_wr),
      .wr_idx(cal_idx),
      .wr_data(reg_wdata[arcb_pkg::CAL_W-1:0]),
      .rd_idx(cal_idx),
      .rd_data(cal_rdata),
      .all_data(cal_values)
   );

   // ==========================================
   // Read path, one cycle after the strobe
   typedef enum {RSEL_NONE, RSEL_REP, RSEL_BUF, RSEL_KEY, RSEL_CAL} arcb_rsel_t;
   arcb_rsel_t rsel_q, rsel_d;
   logic [31:0] rdata_q, rdata_d;
   always_comb begin
      rsel_d = RSEL_NONE;
      if (reg_rd) begin
         if (hit_rep) rsel_d = RSEL_REP;
         else if (hit_buf) rsel_d = RSEL_BUF;
         else if (hit_key) rsel_d = RSEL_KEY;
         else if (hit_cal) rsel_d = RSEL_CAL;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) rsel_q <= RSEL_NONE;
      else rsel_q <= rsel_d;
   end
   // Reserved bits and unmapped addresses read zero
   always_comb begin
      rdata_d = '0;
      unique case (rsel_q)
         RSEL_NONE: rdata_d = '0;
         RSEL_REP: rdata_d = {20'h0, rep_cnt_q, 3'h0, rep_en_q};
         RSEL_BUF: rdata_d = {23'h0, pwrdn_q, nochop_q};
         RSEL_KEY: rdata_d = key_q;
         RSEL_CAL: rdata_d = {17'h0, cal_rdata};
      endcase
   end
   // Memory read is already registered, so data stands in the cycle after the strobe
   assign reg_rdata = rdata_d;

   // ==========================================
   // Outputs
   assign repeat_enable = rep_en_q;
   assign repeat_count = rep_cnt_q;
   assign pd_offset_cancel = pwrdn_q[4];
   assign pd_adc_buf = pwrdn_q[3];
   assign pd_pga = pwrdn_q[2];
   assign pd_front_pos = pwrdn_q[1];
   assign pd_front_neg = pwrdn_q[0];
   assign nochop_offset_cancel = nochop_q[3];
   assign nochop_adc_buf = nochop_q[2];
   assign nochop_pga = nochop_q[1];
   assign nochop_front = nochop_q[0];
   assign cal_unlocked = unlocked_q;

   // ==========================================
   // Checks
   logic [14:0] lp_gain_w;
   assign lp_gain_w = cal_values[1*arcb_pkg::CAL_W +: arcb_pkg::CAL_W];

   locked_hold_a: assert property (@(posedge mclk) disable iff (rst)
      (reg_wr && hit_cal && !unlocked_q) |=> $stable(cal_values))
      else $error("locked calibration write changed state");
   unlock_key_a: assert property (@(posedge mclk) disable iff (rst)
      (reg_wr && hit_key) |=> (cal_unlocked == ($past(reg_wdata) == arcb_pkg::UNLOCK_KEY_VAL)))
      else $error("unlock state does not follow key");
   cal_write_a: assert property (@(posedge mclk) disable iff (rst)
      (reg_wr && hit_cal && unlocked_q && cal_idx == 4'd1) |=> (lp_gain_w == $past(reg_wdata[14:0])))
      else $error("unlocked calibration write lost");
   repeat_field_a: assert property (@(posedge mclk) disable iff (rst)
      (reg_wr && hit_rep) |=> (repeat_count == $past(reg_wdata[11:4]) && repeat_enable == $past(reg_wdata[0])))
      else $error("repeat control not stored");
   buf_map_a: assert property (@(posedge mclk) disable iff (rst)
      (reg_wr && hit_buf) |=> (pd_offset_cancel == $past(reg_wdata[8]) && pd_front_neg == $past(reg_wdata[4])))
      else $error("power-down mapping wrong");
   chop_map_a: assert property (@(posedge mclk) disable iff (rst)
      (reg_wr && hit_buf) |=> (nochop_offset_cancel == $past(reg_wdata[3]) && nochop_front == $past(reg_wdata[0])))
      else $error("chop mapping wrong");
   rep_read_a: assert property (@(posedge mclk) disable iff (rst)
      (reg_rd && hit_rep) |=> (reg_rdata[31:12] == 20'h0 && reg_rdata[3:1] == 3'h0))
      else $error("reserved repeat bits not zero");
   cal_read_a: assert property (@(posedge mclk) disable iff (rst)
      (reg_rd && hit_cal) |=> (reg_rdata[31:15] == 17'h0))
      else $error("reserved calibration bits not zero");
   reset_gain_a: assert property (@(posedge mclk)
      $fell(rst) |-> (lp_gain_w == arcb_pkg::GAIN_CAL_RST && !cal_unlocked))
      else $error("gain not unity after reset");

   unlock_c: cover property (@(posedge mclk) disable iff (rst) (reg_wr && hit_key) ##1 cal_unlocked);
   cal_wr_c: cover property (@(posedge mclk) disable iff (rst) cal_wr);
   locked_wr_c: cover property (@(posedge mclk) disable iff (rst) reg_wr && hit_cal && !unlocked_q);
   rep_en_c: cover property (@(posedge mclk) disable iff (rst) $rose(repeat_enable));
endmodule // arcb_regs

// ---- rtl/arcb_pkg.sv ----
// Package: register map, field layout and reset values of the ADC register bank
package arcb_pkg;
   // ==========================================
   // Register offsets (byte addresses)
   localparam logic [15:0] REPEAT_CTRL_OFF = 16'h21f0;
   localparam logic [15:0] UNLOCK_KEY_OFF = 16'h2230;
   localparam logic [15:0] BUF_CFG_OFF = 16'h238c;
   localparam int NUM_CAL = 16;
   // Calibration registers, index order: offset, gain pairs per channel
   // 0/1 low power TIA, 2/3 fast TIA, 4/5 aux x1, 6/7 x1.5, 8/9 x2, 10/11 x4, 12/13 x9, 14/15 temp sensor
   localparam logic [15:0] CAL_OFF [NUM_CAL] = '{
      16'h2288, 16'h228c, 16'h2234, 16'h2284, 16'h2244, 16'h2240, 16'h22cc, 16'h2270,
      16'h22c8, 16'h2274, 16'h22d4, 16'h2278, 16'h22d0, 16'h2298, 16'h223c, 16'h2238};
   // ==========================================
   // Field positions
   localparam int REPEAT_EN_BIT = 0;
   localparam int REPEAT_CNT_LSB = 4;
   localparam int REPEAT_CNT_W = 8;
   localparam int PWRDN_LSB = 4;
   localparam int PWRDN_W = 5;
   localparam int NOCHOP_LSB = 0;
   localparam int NOCHOP_W = 4;
   localparam int CAL_W = 15;
   // ==========================================
   // Reset values and key
   localparam logic [31:0] REPEAT_CTRL_RST = 32'h0000_0160;
   localparam logic [31:0] BUF_CFG_RST = 32'h005f_3d00;
   localparam logic [31:0] UNLOCK_KEY_RST = 32'h0000_0000;
   localparam logic [31:0] UNLOCK_KEY_VAL = 32'hde87_a5af;
   localparam logic [14:0] OFFSET_CAL_RST = 15'h0000;
   localparam logic [14:0] GAIN_CAL_RST = 15'h4000;
endpackage

// ---- rtl/arcb_cal_mem.sv ----
// Calibration store: offset and gain words with registered read data
`timescale 1ns/1ns
module arcb_cal_mem #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 15
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Write port
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   // Read port
   input wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic [WIDTH-1:0] rd_data,
   // Every entry for the datapath
   output logic [DEPTH*WIDTH-1:0] all_data
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [WIDTH-1:0] rd_q;

   // ==========================================
   // Storage; even entries are offsets, odd are gains
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_ent
         always_comb begin
            mem_d[gi] = mem_q[gi];
            if (wr_en && wr_idx == gi[$clog2(DEPTH)-1:0]) mem_d[gi] = wr_data;
         end
         always_ff @(posedge mclk) begin
            if (rst) mem_q[gi] <= (gi % 2 == 0) ? arcb_pkg::OFFSET_CAL_RST : arcb_pkg::GAIN_CAL_RST;
            else mem_q[gi] <= mem_d[gi];
         end
         assign all_data[gi*WIDTH +: WIDTH] = mem_q[gi];
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (rst) rd_q <= '0;
      else rd_q <= mem_q[rd_idx];
   end
   assign rd_data = rd_q;
endmodule // arcb_cal_mem

// ---- verif/arcb_regs_bench.sv ----
// Self-checking bench for the ADC repeat, buffer and calibration register bank
`timescale 1ns/1ns
module arcb_regs_bench;
   // ==========================================
   // Signals
   logic mclk;
   logic rst;
   logic [15:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rdata;
   logic repeat_enable;
   logic [7:0] repeat_count;
   logic [8:0] buf_out;
   logic cal_unlocked;
   logic [arcb_pkg::NUM_CAL*arcb_pkg::CAL_W-1:0] cal_values;
   logic [14:0] cal_m [16];
   logic [31:0] rec [2] = '{32'h005f_3d0f, 32'h005f_3d04};
   int miscompares;
   int check_count;
   int cycles;
   arcb_regs dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .repeat_enable(repeat_enable), .repeat_count(repeat_count),
      .pd_offset_cancel(buf_out[8]), .pd_adc_buf(buf_out[7]), .pd_pga(buf_out[6]), .pd_front_pos(buf_out[5]),
      .pd_front_neg(buf_out[4]), .nochop_offset_cancel(buf_out[3]), .nochop_adc_buf(buf_out[2]),
      .nochop_pga(buf_out[1]), .nochop_front(buf_out[0]), .cal_unlocked(cal_unlocked), .cal_values(cal_values));
   // ==========================================
   // Clock and hang guard
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end
   // ==========================================
   // Access and compare tasks
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // Strobe stays up so back-to-back writes need no gap; idle lowers it
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
   endtask
   task automatic idle();
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      check($sformatf("read of %h", a), exp, reg_rdata);
   endtask
   task automatic cal_reset_model();
      for (int i = 0; i < 16; i++) begin
         cal_m[i] = (i % 2 == 1) ? 15'h4000 : 15'h0000;
      end
   endtask
   // Write every calibration word, then compare read-back and outputs with the model
   task automatic cal_pass(input logic [31:0] base, input logic take);
      for (int i = 0; i < 16; i++) begin
         wr(arcb_pkg::CAL_OFF[i], base + 32'(i));
         if (take) cal_m[i] = base[14:0] + 15'(i);
      end
      idle();
      for (int i = 0; i < 16; i++) begin
         rd(arcb_pkg::CAL_OFF[i], {17'h0, cal_m[i]});
         check("calibration output", {17'h0, cal_m[i]}, {17'h0, cal_values[i*15 +: 15]});
      end
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ==========================================
   // Test sequence
   initial begin
      rst = 1'b1;
      reg_addr = 16'h0000;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      cycles = 0;
      cal_reset_model();
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      rd(arcb_pkg::REPEAT_CTRL_OFF, 32'h0000_0160);
      rd(arcb_pkg::BUF_CFG_OFF, 32'h0000_0100);
      rd(arcb_pkg::UNLOCK_KEY_OFF, 32'h0000_0000);
      check("buffer outputs", 32'h0000_0100, {23'h0, buf_out});
      check("repeat enable", 32'h0, {31'h0, repeat_enable});
      // Full count with reserved bits set
      wr(arcb_pkg::REPEAT_CTRL_OFF, 32'hffff_fff1);
      idle();
      check("repeat enable", 32'h1, {31'h0, repeat_enable});
      check("repeat count", 32'hff, {24'h0, repeat_count});
      rd(arcb_pkg::REPEAT_CTRL_OFF, 32'h0000_0ff1);
      wr(arcb_pkg::REPEAT_CTRL_OFF, 32'h0000_0010);
      idle();
      check("repeat enable", 32'h0, {31'h0, repeat_enable});
      check("repeat count", 32'h1, {24'h0, repeat_count});
      // Walk one bit so a swapped stage shows at once
      for (int i = 0; i < 9; i++) begin
         wr(arcb_pkg::BUF_CFG_OFF, 32'hffff_fe00 | (32'h1 << i));
         idle();
         check("buffer outputs", 32'h1 << i, {23'h0, buf_out});
      end
      for (int i = 0; i < 2; i++) begin
         wr(arcb_pkg::BUF_CFG_OFF, rec[i]);
         rd(arcb_pkg::BUF_CFG_OFF, rec[i] & 32'h0000_01ff);
         check("buffer outputs", rec[i] & 32'h0000_01ff, {23'h0, buf_out});
      end
      // Locked, then unlocked with the key written just before
      cal_pass(32'h0000_7fff, 1'b0);
      wr(arcb_pkg::UNLOCK_KEY_OFF, 32'hde87_a5af);
      cal_pass(32'hffff_7fff, 1'b1);
      check("unlock flag", 32'h1, {31'h0, cal_unlocked});
      rd(arcb_pkg::UNLOCK_KEY_OFF, 32'hde87_a5af);
      wr(arcb_pkg::UNLOCK_KEY_OFF, 32'hde87_a5ae);
      cal_pass(32'h0000_0155, 1'b0);
      check("unlock flag", 32'h0, {31'h0, cal_unlocked});
      // Unmapped place and one-cycle read data
      wr(16'h2300, 32'hffff_ffff);
      rd(16'h2300, 32'h0000_0000);
      @(posedge mclk);
      #1;
      check("idle read data", 32'h0000_0000, reg_rdata);
      rd(arcb_pkg::REPEAT_CTRL_OFF, 32'h0000_0010);
      // Reset in mid-run clears written calibration and relocks
      wr(arcb_pkg::UNLOCK_KEY_OFF, 32'hde87_a5af);
      cal_pass(32'h0000_2222, 1'b1);
      @(posedge mclk);
      rst <= 1'b1;
      @(posedge mclk);
      rst <= 1'b0;
      cal_reset_model();
      rd(arcb_pkg::REPEAT_CTRL_OFF, 32'h0000_0160);
      check("unlock flag", 32'h0, {31'h0, cal_unlocked});
      cal_pass(32'h0000_3333, 1'b0);
      results();
   end
endmodule // arcb_regs_bench
